//--- slps_regs.vh
// slps_regs.vh: constants for the stream to legacy packet shim
// assumes: included by the shim design files, plain Verilog-2005
`ifndef SLPS_REGS_VH
`define SLPS_REGS_VH
// datapath width selector values
`define SLPS_W32 2'h0
`define SLPS_W64 2'h1
`define SLPS_W128 2'h2
// receive user sideband field positions
`define SLPS_RUSER_W 22
`define SLPS_SOF_LO 10
`define SLPS_SOF_HI 14
`define SLPS_EOF_LO 17
`define SLPS_EOF_HI 21
`define SLPS_ERRFWD_BIT 1
`define SLPS_BAR_LO 2
`define SLPS_BAR_HI 9
// transmit user sideband positions
`define SLPS_TUSER_W 4
`define SLPS_TUSER_ERRFWD 1
`define SLPS_TUSER_STR 2
`define SLPS_TUSER_DSC 3
// keep value meaning all 8 bytes present
`define SLPS_KEEP64_FULL 8'hFF
// discontinue delay in clock cycles
`define SLPS_DSC_DELAY 1
// register bus offsets (byte addresses)
`define SLPS_REG_CTRL 8'h00
`define SLPS_REG_STAT 8'h04
`define SLPS_CTRL_NPACC 0
`define SLPS_CTRL_WIDTH_LO 1
`define SLPS_CTRL_WIDTH_HI 2
`define SLPS_CTRL_RST 8'h01
`endif

//--- slps_dw_swap.v
// slps_dw_swap.v: reverses dword lanes of a 128-bit word per width mode
// assumes: width code from slps_regs.vh; pure combinational
`timescale 1ns/1ps
`default_nettype none
`include "slps_regs.vh"
module slps_dw_swap (
   input wire [1:0] width, // datapath width code
   input wire [127:0] din, // data in
   output reg [127:0] dout // lane-reversed data out
);
   wire [127:0] rev;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_lane
         assign rev[g*32 +: 32] = din[(3-g)*32 +: 32];
      end
   endgenerate
   always @* begin
      dout = din;
      if (width == `SLPS_W64) begin
         // upper half unused in 64-bit mode, passed through
         dout[63:32] = din[31:0];
         dout[31:0] = din[63:32];
      end else if (width == `SLPS_W128) begin
         dout = rev;
      end
   end
endmodule
`default_nettype wire

//--- slps_rx_frame.v
// slps_rx_frame.v: rebuilds legacy receive framing (sof, eof, remainder)
// assumes: stream inputs synchronous to clk; reset is synchronous copy
`timescale 1ns/1ps
`default_nettype none
`include "slps_regs.vh"
module slps_rx_frame (
   input wire clk, // core user clock
   input wire rst, // synchronous reset, active high
   input wire [1:0] width, // datapath width code
   input wire rx_valid, // stream receive valid
   input wire rx_ready, // stream receive ready
   input wire rx_last, // stream receive last (unused in 128)
   input wire [7:0] rx_keep, // stream byte keep, 64-bit mode
   input wire [4:0] rx_frame_begin_field, // 128-bit start field
   input wire [4:0] rx_frame_end_field, // 128-bit end field
   output reg sof_n, // recreated start-of-frame, active low
   output reg eof_n, // recreated end-of-frame, active low
   output reg [1:0] rem_n // recreated remainder, active low
);
   reg in_packet_ff;
   reg nxt_in_packet;
   reg rem1;
   always @* begin
      nxt_in_packet = in_packet_ff;
      if (rx_valid && rx_ready)
         nxt_in_packet = ~rx_last;
   end
   always @(posedge clk) begin
      if (rst)
         in_packet_ff <= 1'b0;
      else
         in_packet_ff <= nxt_in_packet;
   end
   always @* begin
      rem1 = (rx_frame_begin_field[4] & rx_frame_end_field[4] &
              rx_frame_end_field[3]) |
             (~rx_frame_begin_field[4] & rx_frame_end_field[4] &
              rx_frame_end_field[3]) |
             (rx_frame_begin_field[4] & ~rx_frame_end_field[4] &
              ~rx_frame_begin_field[3]);
      if (width == `SLPS_W128) begin
         sof_n = ~rx_frame_begin_field[4];
         eof_n = ~rx_frame_end_field[4];
         rem_n = {~rem1, ~rx_frame_end_field[2]};
      end else begin
         sof_n = ~(rx_valid & ~in_packet_ff);
         eof_n = ~rx_last;
         // remainder only meaningful on eof cycles
         if (width == `SLPS_W64)
            rem_n = {1'b1, ~(rx_last &
               (rx_keep != `SLPS_KEEP64_FULL))};
         else
            rem_n = 2'h3;
      end
   end
endmodule
`default_nettype wire

//--- slps_shim.v
// slps_shim.v: stream to legacy active-low packet interface adapter
// assumes: single user clock, Wishbone classic register slave
// What this block does
// - 64/128-bit paths reverse dword lane order, bytes in dwords kept
// - no stream start-of-frame at 32/64 bits; legacy tx sof ignored
// - 128-bit rx start-of-frame is inverse of sideband bit 14
// - stream strobes bytes every beat; legacy remainders dwords on eof
// - 128-bit rx last held low; boundaries in sideband fields
// - rx discontinue happens only on loss of link; tx discontinue comes from lg_tx_src_dsc_n
// - discontinued packet padded to full length, last still given
// - other legacy controls are opposite polarity of stream ones
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "slps_regs.vh"
module slps_shim (
   input wire ref_clk, // core user clock, 250 MHz
   input wire rst_n, // reset, active low, asynchronous assert
   // wishbone classic slave
   input wire wb_cyc_i, // bus cycle
   input wire wb_stb_i, // strobe
   input wire wb_we_i, // write enable
   input wire [7:0] wb_adr_i, // byte address
   input wire [3:0] wb_sel_i, // byte selects
   input wire [31:0] wb_dat_i, // write data
   output reg [31:0] wb_dat_o, // read data
   output reg wb_ack_o, // acknowledge
   // link status from core
   input wire user_lnk_up, // link up, active high
   // legacy transmit side (user)
   input wire [127:0] lg_tx_data, // legacy tx data
   input wire lg_tx_sof_n, // legacy tx sof, unused
   input wire lg_tx_eof_n, // legacy tx eof, active low
   input wire [1:0] lg_tx_rem_n, // legacy tx remainder, active low
   input wire lg_tx_src_rdy_n, // legacy tx valid, active low
   output reg lg_tx_dst_rdy_n, // legacy tx ready, active low
   input wire lg_tx_src_dsc_n, // legacy tx discontinue
   input wire lg_tx_str_n, // legacy streaming hint
   input wire lg_tx_errfwd_n, // legacy error forward
   // stream transmit side (core)
   output reg [127:0] s_axis_tx_tdata, // stream tx data
   output reg [15:0] s_axis_tx_tkeep, // stream tx byte keep
   output reg s_axis_tx_tlast, // stream tx last
   output reg s_axis_tx_tvalid, // stream tx valid
   input wire s_axis_tx_tready, // stream tx ready
   output reg [3:0] s_axis_tx_tuser, // stream tx sideband
   // stream receive side (core)
   input wire [127:0] m_axis_rx_tdata, // stream rx data
   input wire [15:0] m_axis_rx_tkeep, // stream rx keep
   input wire m_axis_rx_tlast, // stream rx last
   input wire m_axis_rx_tvalid, // stream rx valid
   output reg m_axis_rx_tready, // stream rx ready
   input wire [21:0] m_axis_rx_tuser, // stream rx sideband
   output reg nonposted_accept, // non-posted accept to core
   // legacy receive side (user)
   output reg [127:0] lg_rx_data, // legacy rx data
   output reg lg_rx_sof_n, // legacy rx sof, active low
   output reg lg_rx_eof_n, // legacy rx eof, active low
   output reg [1:0] lg_rx_rem_n, // legacy rx remainder, active low
   output reg lg_rx_src_rdy_n, // legacy rx valid, active low
   input wire lg_rx_dst_rdy_n, // legacy rx ready, active low
   output reg lg_rx_src_dsc_n, // legacy rx discontinue, active low
   output reg lg_rx_errfwd_n, // legacy rx error forward
   output reg [7:0] lg_rx_bar_hit_n, // legacy rx bar hit, active low
   input wire lg_nonposted_accept_n // legacy np ok, active low
);
   reg rst_s1_ff, rst_s2_ff;
   wire rst;
   reg [7:0] ctrl_ff;
   reg dsc_ff;
   reg [31:0] nxt_rd;
   wire [1:0] width;
   wire [127:0] tx_swapped, rx_swapped;
   wire rx_sof_n, rx_eof_n;
   wire [1:0] rx_rem_n;
   wire wb_req;
   reg [15:0] tx_keep;

   // reset released through two flops; async assert only
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= 1'b1;
      end else begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   assign rst = rst_s2_ff;

   assign width = ctrl_ff[`SLPS_CTRL_WIDTH_HI:`SLPS_CTRL_WIDTH_LO];
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   // control register: width mode and software np-accept enable
   always @(posedge ref_clk) begin
      if (rst)
         ctrl_ff <= `SLPS_CTRL_RST;
      else if (wb_req && wb_we_i && wb_sel_i[0] &&
               wb_adr_i == `SLPS_REG_CTRL)
         ctrl_ff <= wb_dat_i[7:0];
   end

   always @* begin
      case (wb_adr_i)
         `SLPS_REG_CTRL: nxt_rd = {24'h000000, ctrl_ff};
         `SLPS_REG_STAT: nxt_rd = {29'h0000000, dsc_ff, user_lnk_up,
                                   m_axis_rx_tvalid};
         default: nxt_rd = 32'h00000000;
      endcase
   end

   // one-wait-state answer; unmapped reads return zero
   always @(posedge ref_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req)
            wb_dat_o <= nxt_rd;
      end
   end

   slps_dw_swap u_tx_swap (
      .width(width),
      .din(lg_tx_data),
      .dout(tx_swapped)
   );
   slps_dw_swap u_rx_swap (
      .width(width),
      .din(m_axis_rx_tdata),
      .dout(rx_swapped)
   );
   slps_rx_frame u_rx_frame (
      .clk(ref_clk),
      .rst(rst),
      .width(width),
      .rx_valid(m_axis_rx_tvalid),
      .rx_ready(~lg_rx_dst_rdy_n),
      .rx_last(m_axis_rx_tlast),
      .rx_keep(m_axis_rx_tkeep[7:0]),
      .rx_frame_begin_field(m_axis_rx_tuser[`SLPS_SOF_HI:`SLPS_SOF_LO]),
      .rx_frame_end_field(m_axis_rx_tuser[`SLPS_EOF_HI:`SLPS_EOF_LO]),
      .sof_n(rx_sof_n),
      .eof_n(rx_eof_n),
      .rem_n(rx_rem_n)
   );

   // legacy tx remainder to byte keep; full keep on non-eof beats
   always @* begin
      tx_keep = 16'hFFFF;
      if (!lg_tx_eof_n) begin
         if (width == `SLPS_W64)
            tx_keep = lg_tx_rem_n[0] ? 16'h00FF : 16'h000F;
         else if (width == `SLPS_W128)
            case (lg_tx_rem_n)
               2'h0: tx_keep = 16'hFFFF;
               2'h1: tx_keep = 16'h0FFF;
               2'h2: tx_keep = 16'h00FF;
               default: tx_keep = 16'h000F;
            endcase
         else
            tx_keep = 16'h000F;
      end
   end

   // tx path registered: one-stage pipe, stalls on core back-pressure.
   // lg_tx_sof_n ignored; the stream side carries no start marker
   always @(posedge ref_clk) begin
      if (rst) begin
         s_axis_tx_tdata <= 128'h0;
         s_axis_tx_tkeep <= 16'h0000;
         s_axis_tx_tlast <= 1'b0;
         s_axis_tx_tvalid <= 1'b0;
         s_axis_tx_tuser <= 4'h0;
         lg_tx_dst_rdy_n <= 1'b1;
      end else begin
         lg_tx_dst_rdy_n <= ~s_axis_tx_tready;
         if (!s_axis_tx_tvalid || s_axis_tx_tready) begin
            s_axis_tx_tvalid <= ~lg_tx_src_rdy_n & ~lg_tx_dst_rdy_n;
            s_axis_tx_tdata <= tx_swapped;
            s_axis_tx_tkeep <= tx_keep;
            s_axis_tx_tlast <= ~lg_tx_eof_n;
            s_axis_tx_tuser <= {~lg_tx_src_dsc_n, ~lg_tx_str_n,
                                ~lg_tx_errfwd_n, 1'b0};
         end
      end
   end

   // rx path: registered copy, ready forwarded; caveat: ready is one
   // cycle late, so the user must still take a beat the cycle after it drops ready
   always @(posedge ref_clk) begin
      if (rst) begin
         lg_rx_data <= 128'h0;
         lg_rx_sof_n <= 1'b1;
         lg_rx_eof_n <= 1'b1;
         lg_rx_rem_n <= 2'h3;
         lg_rx_src_rdy_n <= 1'b1;
         lg_rx_errfwd_n <= 1'b1;
         lg_rx_bar_hit_n <= 8'hFF;
         m_axis_rx_tready <= 1'b0;
         nonposted_accept <= 1'b1;
         dsc_ff <= 1'b0;
         lg_rx_src_dsc_n <= 1'b1;
      end else begin
         m_axis_rx_tready <= ~lg_rx_dst_rdy_n;
         lg_rx_data <= rx_swapped;
         lg_rx_sof_n <= rx_sof_n;
         lg_rx_eof_n <= rx_eof_n;
         lg_rx_rem_n <= rx_rem_n;
         lg_rx_src_rdy_n <= ~m_axis_rx_tvalid;
         lg_rx_errfwd_n <= ~m_axis_rx_tuser[`SLPS_ERRFWD_BIT];
         lg_rx_bar_hit_n <= ~m_axis_rx_tuser[`SLPS_BAR_HI:`SLPS_BAR_LO];
         // ctrl bit0 set keeps accept high when reordering unused
         nonposted_accept <= ~lg_nonposted_accept_n |
            ctrl_ff[`SLPS_CTRL_NPACC];
         // loss of link is the only discontinue cause; packet still
         // ends with last, so framing logic needs no abort path
         dsc_ff <= ~user_lnk_up;
         lg_rx_src_dsc_n <= user_lnk_up;
      end
   end
endmodule
`default_nettype wire

//--- slps_user_model.sv
// slps_user_model.sv: legacy-side user logic that takes received packets
// assumes: runs on the shim's user clock; stall and np_full come from bench
`timescale 1ns/1ps
`default_nettype none
module slps_user_model (
   input wire logic clk, // user clock
   input wire logic stall, // hold off receive traffic
   input wire logic np_full, // no room for more non-posted packets
   output logic lg_rx_dst_rdy_n, // legacy receive ready, active low
   output logic lg_nonposted_accept_n // non-posted room, active low
);
   // ready is low-true on this side of the shim
   always @(posedge clk) lg_rx_dst_rdy_n <= stall;
   // dropped a clock ahead of the last packet still taken
   always @(posedge clk) lg_nonposted_accept_n <= np_full;
endmodule
`default_nettype wire

//--- slps_shim_sva.sv
// slps_shim_sva.sv: port-level checks for the packet shim
// assumes: bound to slps_shim; width and accept force tracked from writes
`timescale 1ns/1ps
`default_nettype none
module slps_shim_sva (
   input wire logic ref_clk, // user clock
   input wire logic rst_n, // reset, active low
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write enable
   input wire logic [7:0] wb_adr_i, // address
   input wire logic [31:0] wb_dat_i, // write data
   input wire logic wb_ack_o, // acknowledge
   input wire logic user_lnk_up, // link up
   input wire logic [127:0] m_axis_rx_tdata, // stream rx data
   input wire logic [15:0] m_axis_rx_tkeep, // stream rx keep
   input wire logic m_axis_rx_tlast, // stream rx last
   input wire logic m_axis_rx_tvalid, // stream rx valid
   input wire logic [21:0] m_axis_rx_tuser, // stream rx sideband
   input wire logic lg_rx_dst_rdy_n, // legacy rx ready
   input wire logic lg_nonposted_accept_n, // legacy np room
   input wire logic nonposted_accept, // np accept to core
   input wire logic [127:0] lg_rx_data, // legacy rx data
   input wire logic lg_rx_sof_n, // legacy rx sof
   input wire logic [1:0] lg_rx_rem_n, // legacy rx remainder
   input wire logic lg_rx_src_rdy_n, // legacy rx valid
   input wire logic lg_rx_src_dsc_n // legacy rx discontinue
);
   logic [3:0] up_ff;
   logic [1:0] wid_ff;
   logic npf_ff;
   logic inpk_ff;
   wire live = up_ff[3];
   wire [4:0] bf = m_axis_rx_tuser[14:10];
   wire [4:0] ef = m_axis_rx_tuser[21:17];
   wire r1 = (ef[4] & ef[3]) | (bf[4] & !ef[4] & !bf[3]);
   wire wr_ctrl = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o
      & (wb_adr_i == 8'h00);
   // the design leaves reset a few edges after rst_n rises
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         up_ff <= 4'h0;
         wid_ff <= 2'h0;
         npf_ff <= 1'b1;
      end else begin
         up_ff <= {up_ff[2:0], 1'b1};
         if (wr_ctrl) begin
            wid_ff <= wb_dat_i[2:1];
            npf_ff <= wb_dat_i[0];
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!live)
         inpk_ff <= 1'b0;
      else if (m_axis_rx_tvalid && !lg_rx_dst_rdy_n)
         inpk_ff <= !m_axis_rx_tlast;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!live);
   a_dsc_delay: assert property (
      lg_rx_src_dsc_n == $past(user_lnk_up))
      else $error("discontinue is not link-up one cycle late");
   a_sof_narrow: assert property ($past(wid_ff) != 2'h2 |->
      lg_rx_sof_n == !($past(m_axis_rx_tvalid) && !$past(inpk_ff)))
      else $error("rebuilt start of frame wrong at 32/64 bits");
   a_sof_wide: assert property ($past(wid_ff) == 2'h2 |->
      lg_rx_sof_n == !$past(m_axis_rx_tuser[14]))
      else $error("start of frame not inverse of begin bit");
   a_rem_narrow: assert property ($past(wid_ff) == 2'h1 |->
      lg_rx_rem_n == {1'b1, !($past(m_axis_rx_tlast)
      && $past(m_axis_rx_tkeep[7:0]) != 8'hFF)})
      else $error("64-bit remainder wrong");
   a_rem_wide: assert property ($past(wid_ff) == 2'h2 |->
      lg_rx_rem_n == {!$past(r1), !$past(ef[2])})
      else $error("128-bit remainder wrong");
   a_swap_wide: assert property ($past(wid_ff) == 2'h2 |->
      lg_rx_data == {$past(m_axis_rx_tdata[31:0]),
      $past(m_axis_rx_tdata[63:32]), $past(m_axis_rx_tdata[95:64]),
      $past(m_axis_rx_tdata[127:96])})
      else $error("128-bit lanes not reversed");
   a_swap_mid: assert property ($past(wid_ff) == 2'h1 |->
      lg_rx_data[63:0] == {$past(m_axis_rx_tdata[31:0]),
      $past(m_axis_rx_tdata[63:32])})
      else $error("64-bit lanes not reversed");
   a_valid_pol: assert property (lg_rx_src_rdy_n ==
      !$past(m_axis_rx_tvalid))
      else $error("legacy valid not inverse of stream valid");
   a_np_follow: assert property (nonposted_accept ==
      ($past(npf_ff) || !$past(lg_nonposted_accept_n)))
      else $error("non-posted accept wrong");
   c_wide_sof: cover property ($past(wid_ff) == 2'h2 && !lg_rx_sof_n);
   c_dsc: cover property (!lg_rx_src_dsc_n);
   c_np_off: cover property (!nonposted_accept);
endmodule
bind slps_shim slps_shim_sva i_sva (.ref_clk, .rst_n, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .user_lnk_up,
   .m_axis_rx_tdata, .m_axis_rx_tkeep, .m_axis_rx_tlast, .m_axis_rx_tvalid,
   .m_axis_rx_tuser, .lg_rx_dst_rdy_n, .lg_nonposted_accept_n, .nonposted_accept,
   .lg_rx_data, .lg_rx_sof_n, .lg_rx_rem_n, .lg_rx_src_rdy_n,
   .lg_rx_src_dsc_n);
`default_nettype wire

//--- slps_shim_tb.sv
// slps_shim_tb.sv: directed bench for the packet shim
// assumes: slps_user_model plays the legacy user; checker bound separately
`timescale 1ns/1ps
`default_nettype none
module slps_shim_tb;
   localparam logic [127:0] D = 128'h0123456789ABCDEFFEDCBA9876543210;
   logic ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i, lg_rx_bar_hit_n;
   logic [3:0] wb_sel_i, s_axis_tx_tuser;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [127:0] lg_tx_data, s_axis_tx_tdata, m_axis_rx_tdata, lg_rx_data;
   logic lg_tx_sof_n, lg_tx_eof_n, lg_tx_src_rdy_n, lg_tx_dst_rdy_n;
   logic lg_tx_src_dsc_n, lg_tx_str_n, lg_tx_errfwd_n, user_lnk_up;
   logic [1:0] lg_tx_rem_n, lg_rx_rem_n;
   logic [15:0] s_axis_tx_tkeep, m_axis_rx_tkeep;
   logic s_axis_tx_tlast, s_axis_tx_tvalid, s_axis_tx_tready;
   logic m_axis_rx_tlast, m_axis_rx_tvalid, m_axis_rx_tready;
   logic [21:0] m_axis_rx_tuser;
   logic lg_rx_sof_n, lg_rx_eof_n, lg_rx_src_rdy_n, lg_rx_dst_rdy_n;
   logic lg_rx_src_dsc_n, lg_rx_errfwd_n, lg_nonposted_accept_n, nonposted_accept;
   logic stall, np_full;
   logic [4:0] bft [6] = '{5'h10, 5'h10, 5'h10, 5'h00, 5'h10, 5'h18};
   logic [4:0] eft [6] = '{5'h13, 5'h17, 5'h1B, 5'h1F, 5'h00, 5'h00};
   logic [1:0] remt [6] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h1, 2'h3};
   int error_cnt, samples_checked;
   slps_user_model i_user (.clk(ref_clk), .stall(stall), .np_full(np_full),
      .lg_rx_dst_rdy_n(lg_rx_dst_rdy_n), .lg_nonposted_accept_n(lg_nonposted_accept_n));
   slps_shim i_dut (.*);
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   function automatic logic [127:0] sw(input logic [127:0] d);
      sw = {d[31:0], d[63:32], d[95:64], d[127:96]};
   endfunction
   task automatic chk(input string nm, input logic [127:0] e, g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) error_cnt++;
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge ref_clk);
   endtask
   // one receive beat; outputs are settled when this returns
   task automatic rx(input logic v, l, input logic [15:0] k,
      input logic [21:0] u);
      @(posedge ref_clk);
      {m_axis_rx_tvalid, m_axis_rx_tlast} <= {v, l};
      m_axis_rx_tdata <= D;
      m_axis_rx_tkeep <= k;
      m_axis_rx_tuser <= u;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   task stop_test;
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #40000;
      error_cnt++;
      stop_test;
   end
   initial begin
      rst_n = 1'b0; // low-true system reset
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      wb_sel_i = 4'hF;
      {user_lnk_up, s_axis_tx_tready, stall, np_full} = 4'hC;
      {lg_tx_sof_n, lg_tx_eof_n, lg_tx_src_rdy_n, lg_tx_rem_n} = 5'h1C;
      {lg_tx_src_dsc_n, lg_tx_str_n, lg_tx_errfwd_n} = 3'h7;
      lg_tx_data = 128'h0;
      {m_axis_rx_tvalid, m_axis_rx_tlast, m_axis_rx_tdata} = '0;
      {m_axis_rx_tkeep, m_axis_rx_tuser} = '0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (20) @(posedge ref_clk);
      // ready input is high, so only the reset can hold this high
      chk("reset tx ready", 1'b1, lg_tx_dst_rdy_n);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      wb(1'b0, 8'h00, 32'h0);
      chk("ctrl reset", 32'h1, rd);
      wb(1'b0, 8'h10, 32'h0);
      chk("unmapped read", 32'h0, rd);
      rx(1'b1, 1'b0, 16'hF, 22'h00000E);
      chk("sof 32 first", 1'b0, lg_rx_sof_n);
      chk("errfwd", 1'b0, lg_rx_errfwd_n);
      chk("bar hit", 8'hFC, lg_rx_bar_hit_n);
      chk("data 32", D[31:0], lg_rx_data[31:0]);
      rx(1'b1, 1'b1, 16'hF, 22'h0);
      chk("sof 32 next", 1'b1, lg_rx_sof_n);
      chk("rx valid", 1'b0, lg_rx_src_rdy_n);
      stall <= 1'b1;
      rx(1'b0, 1'b0, 16'h0, 22'h0);
      chk("rx idle", 1'b1, lg_rx_src_rdy_n);
      // beats refused by the user must not move the in-packet flag
      rx(1'b1, 1'b0, 16'hF, 22'h0);
      rx(1'b1, 1'b1, 16'hF, 22'h0);
      chk("sof stalled", 1'b0, lg_rx_sof_n);
      chk("rx ready", 1'b0, m_axis_rx_tready);
      stall <= 1'b0;
      rx(1'b0, 1'b0, 16'h0, 22'h0);
      wb(1'b1, 8'h00, 32'h3);
      rx(1'b1, 1'b1, 16'h0F, 22'h0);
      chk("rem 64 part", 2'h2, lg_rx_rem_n);
      chk("data 64", sw(D) >> 64, lg_rx_data[63:0]);
      chk("sof 64", 1'b0, lg_rx_sof_n);
      rx(1'b1, 1'b1, 16'hFF, 22'h0);
      chk("rem 64 full", 2'h3, lg_rx_rem_n);
      rx(1'b1, 1'b0, 16'h0F, 22'h0);
      chk("rem 64 mid", 2'h3, lg_rx_rem_n);
      @(posedge ref_clk) user_lnk_up <= 1'b0;
      rx(1'b1, 1'b1, 16'hFF, 22'h0);
      chk("dsc on", 1'b0, lg_rx_src_dsc_n);
      chk("padded end", 1'b0, lg_rx_eof_n);
      wb(1'b0, 8'h04, 32'h0);
      chk("stat link down", 32'h5, rd);
      @(posedge ref_clk) user_lnk_up <= 1'b1;
      rx(1'b0, 1'b0, 16'h0, 22'h0);
      chk("dsc off", 1'b1, lg_rx_src_dsc_n);
      wb(1'b1, 8'h00, 32'h5);
      for (int i = 0; i < 6; i++) begin
         rx(1'b1, 1'b0, 16'hFFFF, {eft[i], 2'h0, bft[i], 10'h0});
         chk("rem 128", remt[i], lg_rx_rem_n);
         chk("sof 128", !bft[i][4], lg_rx_sof_n);
         chk("eof 128", !eft[i][4], lg_rx_eof_n);
      end
      chk("data 128", sw(D), lg_rx_data);
      rx(1'b0, 1'b0, 16'h0, 22'h0);
      @(posedge ref_clk);
      lg_tx_data <= D;
      {lg_tx_src_rdy_n, lg_tx_eof_n, lg_tx_str_n, lg_tx_sof_n} <= 4'h0;
      lg_tx_rem_n <= 2'h1;
      @(posedge ref_clk);
      lg_tx_src_rdy_n <= 1'b1;
      #1;
      chk("tx data", sw(D), s_axis_tx_tdata);
      chk("tx keep", 16'h0FFF, s_axis_tx_tkeep);
      chk("tx end", 2'h3, {s_axis_tx_tlast, s_axis_tx_tvalid});
      chk("tx user", 3'h2, s_axis_tx_tuser[3:1]);
      np_full <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("np forced", 1'b1, nonposted_accept);
      wb(1'b1, 8'h00, 32'h4);
      repeat (2) @(posedge ref_clk);
      chk("np held off", 1'b0, nonposted_accept);
      np_full <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk("np open", 1'b1, nonposted_accept);
      stop_test;
   end
endmodule
`default_nettype wire
